// *** design/cif_top.sv ***
// apb register block: module interrupts, filter 8-10 control, fifo irqs
`include "cif_regs.svh"
module cif_top #(
   parameter int N_FIFO = 16,          // fifos with an interrupt register
   parameter int ADDR_W = 8,           // apb address width
   parameter int N_FLT  = 3            // filters in the control word
) (
   input  wire logic                  sys_clk,
   input  wire logic                  rst_b,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [ADDR_W-1:0]     paddr,
   input  wire cif_pkg::cif_word_t    pwdata,
   output cif_pkg::cif_word_t         prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [8:0]            module_evt,
   input  wire logic [N_FLT-1:0]      filter_hit,
   input  wire logic [N_FIFO-1:0]     fifo_direction_tx,
   input  wire logic [N_FIFO-1:0]     fifo_full,
   input  wire logic [N_FIFO-1:0]     fifo_half,
   input  wire logic [N_FIFO-1:0]     fifo_empty,
   input  wire logic [N_FIFO-1:0]     fifo_msg_arrive,
   output logic                       irq,
   output logic                       route_valid,
   output logic [4:0]                 route_fifo,
   output logic [1:0]                 route_mask_sel,
   output logic                       module_on
);
   import cif_pkg::*;
   // register map, one aligned 32-bit word each:
   //   0x00       module interrupt enables and sticky flags
   //   0x04       filter 8, 9 and 10 control, a byte each
   //   0x08       module control, only the on bit kept
   //   0x40-0x7c  one fifo interrupt word per fifo
   // any other address, or low two bits set, answers
   // with an error and reads zero
   //
   // module interrupt word:
   //   31-27  invalid msg, wake, bus error, system
   //          error and rx overflow enables
   //   19-16  mode, timestamp, rx and tx buffer enables
   //   15-11  flags in the order of the upper enables
   //   3-0    flags in the order of the lower enables
   //   26-20 and 10-4 are holes, never stored
   //
   // filter byte, repeated per filter:
   //   7      filter enable
   //   6-5    acceptance mask number
   //   4-0    destination fifo, 16 and up reserved
   // the top byte of the filter word is a hole too
   //
   // timing at the pins:
   //   a setup gets exactly one cycle of ready,
   //   so no wait states and no counter are needed
   //   read data is caught at the setup edge, so a
   //   register that moves in the access phase shows
   //   its older value
   //   flags land one edge after their event,
   //   irq one edge later
   //   a route follows its match by one edge

   localparam int FW = 8 * N_FLT;      // filter control bits in use
   localparam int IW = $clog2(N_FIFO); // fifo index width

   // apb slave state
   cif_apb_state_e state_ff;           // current phase
   cif_apb_state_e nxt_state;          // next phase
   cif_word_t      prdata_ff;          // read data held for the master
   logic           pready_ff;          // ready in the access phase
   logic           pslverr_ff;         // unmapped address answer

   // register storage
   logic [8:0]     int_en_ff;          // module interrupt enables
   logic [8:0]     int_flag_ff;        // module interrupt flags
   logic [8:0]     nxt_int_flag;       // next flag value
   logic [FW-1:0]  flt_ff;             // filter control fields
   logic [FW-1:0]  nxt_flt;            // next filter control value
   logic           mod_on_ff;          // module on bit
   logic           irq_ff;             // registered interrupt line

   // routing result
   logic           route_valid_ff;     // match routed this cycle
   logic [4:0]     route_fifo_ff;      // destination fifo
   logic [1:0]     route_mask_ff;      // mask chosen by the filter
   logic           nxt_route_valid;    // combinational match found
   logic [4:0]     nxt_route_fifo;     // combinational destination
   logic [1:0]     nxt_route_mask;     // combinational mask

   // decode
   logic           sel_int;            // module interrupt register
   logic           sel_flt;            // filter control word
   logic           sel_mod;            // module control register
   logic           sel_fifo;           // one of the fifo registers
   logic [IW-1:0]  fifo_idx;           // which fifo register
   logic           mapped;             // address hits a register
   logic           wr_commit;          // write takes effect this edge
   logic           on_rise;            // module turned from off to on
   cif_word_t      rd_word;            // read mux output

   // per-filter fields
   logic [N_FLT-1:0] flt_en;           // filter enable bits
   logic [1:0]     flt_msel [N_FLT];   // mask select per filter
   logic [4:0]     flt_fsel [N_FLT];   // fifo select per filter

   // per-fifo slices
   cif_word_t      fifo_rd [N_FIFO];   // read words of each slice
   logic [N_FIFO-1:0] fifo_wr;         // write strobe per slice
   logic [N_FIFO-1:0] fifo_req;        // service request per slice

   // address decode; low two bits must be zero everywhere
   always_comb begin
      sel_int  = (paddr == `CIF_OFS_INT);
      sel_flt  = (paddr == `CIF_OFS_FLT);
      sel_mod  = (paddr == `CIF_OFS_MOD);
      sel_fifo = ((paddr & `CIF_FIFO_AMSK) == `CIF_OFS_FIFO);
      fifo_idx = paddr[IW+1:2];
      mapped   = sel_int | sel_flt | sel_mod | sel_fifo;
   end

   // a write lands only at the edge that samples ready high
   assign wr_commit = (state_ff == CIF_RESP) & psel & penable & pwrite;

   // only two phases: idle, and the one access cycle
   // in which ready stands; a master holding penable
   // longer sees ready only once
   // a setup with penable already high is ignored,
   // so a stuck master cannot fake a second access
   // apb phase tracking
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         CIF_IDLE: begin
            // setup seen: answer in the first access cycle
            if (psel && !penable) begin
               nxt_state = CIF_RESP;
            end
         end
         CIF_RESP: begin
            // access done after one cycle of ready
            nxt_state = CIF_IDLE;
         end
         default: begin
            // illegal code recovers to idle
            nxt_state = CIF_IDLE;
         end
      endcase
   end

   // phase register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= CIF_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ready, error and read data are set up at the setup edge
   // so the master sees a stable answer for the whole access
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= '0;
      end else if (nxt_state == CIF_RESP) begin
         pready_ff  <= 1'b1;
         pslverr_ff <= ~mapped;
         prdata_ff  <= pwrite ? '0 : rd_word;
      end else begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= '0;
      end
   end

   // holes come from the zero default, not storage,
   // so a hole never reads back what was written
   // read mux; holes read zero
   always_comb begin
      rd_word = '0;
      if (sel_int) begin
         // gaps 26-20 and 10-4 stay zero
         rd_word[`CIF_INT_EN_HI:`CIF_INT_EN_LO]   = int_en_ff[8:4];
         rd_word[`CIF_INT_EN2_HI:`CIF_INT_EN2_LO] = int_en_ff[3:0];
         rd_word[`CIF_INT_FL_HI:`CIF_INT_FL_LO]   = int_flag_ff[8:4];
         rd_word[`CIF_INT_FL2_HI:`CIF_INT_FL2_LO] = int_flag_ff[3:0];
      end else if (sel_flt) begin
         rd_word[FW-1:0] = flt_ff;
      end else if (sel_mod) begin
         rd_word[`CIF_MOD_ON] = mod_on_ff;
      end else if (sel_fifo) begin
         rd_word = fifo_rd[fifo_idx];
      end
   end

   // module interrupt enables; unimplemented bits never stored
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         int_en_ff <= `CIF_RST_EN;
      end else if (wr_commit && sel_int) begin
         int_en_ff <= {pwdata[`CIF_INT_EN_HI:`CIF_INT_EN_LO],
                       pwdata[`CIF_INT_EN2_HI:`CIF_INT_EN2_LO]};
      end
   end

   // module on bit; an off-to-on write restarts the module
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         mod_on_ff <= 1'b0;
      end else if (wr_commit && sel_mod) begin
         mod_on_ff <= pwdata[`CIF_MOD_ON];
      end
   end

   assign on_rise = wr_commit & sel_mod & pwdata[`CIF_MOD_ON] & ~mod_on_ff;

   // writing the enables with flag bits at zero
   // leaves pending flags alone
   // events are ored in last: a clear and an event
   // in one cycle leave the flag set, nothing lost
   // flags: write one clears, a new event in the same cycle wins;
   // the system error flag ignores writes and clears on restart
   always_comb begin
      nxt_int_flag = int_flag_ff;
      if (wr_commit && sel_int) begin
         nxt_int_flag = nxt_int_flag & ~({pwdata[`CIF_INT_FL_HI:`CIF_INT_FL_LO],
                        pwdata[`CIF_INT_FL2_HI:`CIF_INT_FL2_LO]} & ~`CIF_SERR_MASK);
      end
      if (on_rise) begin
         nxt_int_flag = nxt_int_flag & ~`CIF_SERR_MASK;
      end
      nxt_int_flag = nxt_int_flag | module_evt;
   end

   // flag register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         int_flag_ff <= `CIF_RST_EN;
      end else begin
         int_flag_ff <= nxt_int_flag;
      end
   end

   // filter fields unpacked once, one byte per filter
   for (genvar g = 0; g < N_FLT; g++) begin : g_flt
      assign flt_en[g]   = flt_ff[8*g+`CIF_FLT_EN];
      assign flt_msel[g] = flt_ff[8*g+`CIF_FLT_MS_HI -: 2];
      assign flt_fsel[g] = flt_ff[8*g+`CIF_FLT_FS_HI -: 5];
   end

   // enable and new fields may go in one write, as
   // the filter was off before it; a running filter
   // needs two writes, off first
   // filter control write; enable always writable,
   // select fields only while their filter is disabled
   always_comb begin
      nxt_flt = flt_ff;
      if (wr_commit && sel_flt) begin
         for (int k = 0; k < N_FLT; k++) begin
            nxt_flt[8*k+`CIF_FLT_EN] = pwdata[8*k+`CIF_FLT_EN];
            if (!flt_en[k]) begin
               nxt_flt[8*k+`CIF_FLT_MS_HI -: 7] = pwdata[8*k+`CIF_FLT_MS_HI -: 7];
            end
         end
      end
   end

   // filter register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         flt_ff <= `CIF_RST_FLT;
      end else begin
         flt_ff <= nxt_flt;
      end
   end

   // the route is registered: the engine sees fifo
   // and mask one edge after the match, and must
   // hold the message that long
   // route a hit; lowest filter wins when several match
   // a reserved fifo code drops the message rather than guess
   always_comb begin
      nxt_route_valid = 1'b0;
      nxt_route_fifo  = '0;
      nxt_route_mask  = '0;
      for (int k = N_FLT - 1; k >= 0; k--) begin
         if (filter_hit[k] && flt_en[k] && !flt_fsel[k][`CIF_FLT_RSV]) begin
            nxt_route_valid = 1'b1;
            nxt_route_fifo  = flt_fsel[k];
            nxt_route_mask  = flt_msel[k];
         end
      end
   end

   // routing result register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         route_valid_ff <= 1'b0;
         route_fifo_ff  <= '0;
         route_mask_ff  <= '0;
      end else begin
         route_valid_ff <= nxt_route_valid;
         route_fifo_ff  <= nxt_route_fifo;
         route_mask_ff  <= nxt_route_mask;
      end
   end

   // one interrupt slice per fifo
   for (genvar f = 0; f < N_FIFO; f++) begin : g_fifo
      // strobe only for the addressed slice
      assign fifo_wr[f] = wr_commit & sel_fifo & (fifo_idx == IW'(f));
      cif_fifo_irq u_fifo_irq (
         .sys_clk    (sys_clk),
         .rst_b      (rst_b),
         .wr_en      (fifo_wr[f]),
         .wdata      (pwdata),
         .dir_tx     (fifo_direction_tx[f]),
         .full       (fifo_full[f]),
         .half       (fifo_half[f]),
         .empty      (fifo_empty[f]),
         .msg_arrive (fifo_msg_arrive[f]),
         .rdata      (fifo_rd[f]),
         .irq_req    (fifo_req[f])
      );
   end

   // a level, not a pulse: high while an enabled
   // flag is set, low one edge after the last clear
   // one level line: any enabled module flag or fifo request;
   // registered so the pin is glitch free, one cycle behind
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(int_flag_ff & int_en_ff) | |fifo_req;
      end
   end

   // outputs straight from flip-flops
   assign prdata         = prdata_ff;
   assign pready         = pready_ff;
   assign pslverr        = pslverr_ff;
   assign irq            = irq_ff;
   assign route_valid    = route_valid_ff;
   assign route_fifo     = route_fifo_ff;
   assign route_mask_sel = route_mask_ff;
   assign module_on      = mod_on_ff;
endmodule // cif_top

// *** design/cif_regs.svh ***
// register offsets, field positions and reset values
`ifndef CIF_REGS_SVH
`define CIF_REGS_SVH
// byte offsets on the apb window
`define CIF_OFS_INT    8'h00
`define CIF_OFS_FLT    8'h04
`define CIF_OFS_MOD    8'h08
`define CIF_OFS_FIFO   8'h40
`define CIF_FIFO_AMSK  8'hc3
// module interrupt register fields
`define CIF_INT_EN_HI  31
`define CIF_INT_EN_LO  27
`define CIF_INT_EN2_HI 19
`define CIF_INT_EN2_LO 16
`define CIF_INT_FL_HI  15
`define CIF_INT_FL_LO  11
`define CIF_INT_FL2_HI 3
`define CIF_INT_FL2_LO 0
`define CIF_SERR_MASK  9'h020
// module control on bit
`define CIF_MOD_ON     15
// filter control fields, one byte per filter
`define CIF_FLT_EN     7
`define CIF_FLT_MS_HI  6
`define CIF_FLT_FS_HI  4
`define CIF_FLT_RSV    4
// fifo interrupt register fields
`define CIF_FI_TXE_HI  26
`define CIF_FI_RXE_HI  19
`define CIF_FI_TXNF    10
`define CIF_FI_OVF     3
// reset values
`define CIF_RST_EN     9'h000
`define CIF_RST_FLT    24'h00_0000
`define CIF_RST_FI     7'h00
`endif

// *** design/cif_pkg.sv ***
// types shared by the interrupt and filter control block
package cif_pkg;
   typedef logic [31:0] cif_word_t;     // apb data word
   // apb slave phases, one-hot
   typedef enum logic [1:0] {
      CIF_IDLE = 2'b01,                 // waiting for setup
      CIF_RESP = 2'b10                  // access phase, ready high
   } cif_apb_state_e;
endpackage : cif_pkg

// *** design/cif_fifo_irq.sv ***
// per-fifo interrupt enables, overflow flag and live fill flags
`include "cif_regs.svh"
module cif_fifo_irq (
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   input  wire logic              wr_en,
   input  wire cif_pkg::cif_word_t wdata,
   input  wire logic              dir_tx,
   input  wire logic              full,
   input  wire logic              half,
   input  wire logic              empty,
   input  wire logic              msg_arrive,
   output cif_pkg::cif_word_t     rdata,
   output logic                   irq_req
);
   import cif_pkg::*;

   logic [2:0] tx_en_ff;   // not-full, half, empty enables
   logic [3:0] rx_en_ff;   // overflow, full, half, not-empty
   logic       ovf_ff;     // sticky receive overflow
   logic [2:0] tx_flag;    // live transmit flags
   logic [2:0] rx_live;    // live receive flags
   logic       ovf_set;    // arrival into a full rx fifo

   // enables: plain read/write bits
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         {tx_en_ff, rx_en_ff} <= `CIF_RST_FI; // both enable groups, 7 bits
      end else if (wr_en) begin
         tx_en_ff <= wdata[`CIF_FI_TXE_HI -: 3];
         rx_en_ff <= wdata[`CIF_FI_RXE_HI -: 4];
      end
   end

   // overflow only counts on a receive fifo
   assign ovf_set = msg_arrive & full & ~dir_tx;

   // sticky overflow; a new event beats a write of zero
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ovf_ff <= 1'b0;
      end else begin
         ovf_ff <= ovf_set | (ovf_ff & ~(wr_en & ~wdata[`CIF_FI_OVF]));
      end
   end

   // fill flags follow the fifo, gated by its direction
   assign tx_flag = {dir_tx & ~full, dir_tx & half, dir_tx & empty};
   assign rx_live = {~dir_tx & full, ~dir_tx & half, ~dir_tx & ~empty};

   // read view: 5 zero, 3 tx en, 4 zero, 4 rx en, 5 zero, 3 tx flag, 4 zero, overflow, 3 rx live
   assign rdata = {5'h00, tx_en_ff, 4'h0, rx_en_ff,
                   5'h00, tx_flag, 4'h0, ovf_ff, rx_live};

   // any enabled condition asks for service
   assign irq_req = |(tx_flag & tx_en_ff) | |({ovf_ff, rx_live} & rx_en_ff);
endmodule // cif_fifo_irq

// *** dv/cif_top_props.sv ***
// concurrent checks on the apb, routing and control ports of cif_top
module cif_top_props #(
   parameter int ADDR_W = 8,          // apb address width
   parameter int N_FLT  = 3           // filters in the control word
) (
   input wire logic               sys_clk,
   input wire logic               rst_b,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [ADDR_W-1:0]  paddr,
   input wire cif_pkg::cif_word_t prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic [N_FLT-1:0]   filter_hit,
   input wire logic               route_valid,
   input wire logic [4:0]         route_fifo,
   input wire logic               module_on
);
   timeunit 1ns;
   timeprecision 1ps;
   import cif_pkg::*;
   // one clock domain, so clock and reset are given once
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   // a setup cycle is answered in the very next cycle
   property p_ready_next; psel && !penable |=> pready && psel && penable; endproperty
   a_ready_next: assert property (p_ready_next) else $error("setup not answered next cycle");
   // ready is a single-cycle strobe, so back-to-back masters never see a stale answer
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held past one cycle");
   property p_idle_rdata; !pready |-> prdata == 32'h0000_0000; endproperty
   a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside access");
   property p_err_ready; pslverr |-> pready; endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   // misaligned byte addresses are refused
   property p_misalign; psel && !penable && paddr[1:0] != 2'b00 |=> pslverr; endproperty
   a_misalign: assert property (p_misalign) else $error("misaligned access accepted");
   property p_int_resv; pready && !pwrite && paddr == 8'h00 |-> prdata[26:20] == 7'h00; endproperty
   a_int_resv: assert property (p_int_resv) else $error("unused interrupt bits not zero");
   property p_fifo_resv; pready && !pwrite && paddr[7:6] == 2'b01 |-> prdata[31:27] == 5'h00; endproperty
   a_fifo_resv: assert property (p_fifo_resv) else $error("unused fifo bits not zero");
   property p_route_range; route_valid |-> route_fifo < 5'h10; endproperty
   a_route_range: assert property (p_route_range) else $error("route to reserved fifo");
   // a route only ever follows a filter match one cycle earlier
   property p_route_cause; route_valid |-> $past(|filter_hit); endproperty
   a_route_cause: assert property (p_route_cause) else $error("route without match");
   property p_on_write; $changed(module_on) |-> $past(psel && penable && pwrite && paddr == 8'h08); endproperty
   a_on_write: assert property (p_on_write) else $error("on bit moved without write");
endmodule : cif_top_props

bind cif_top cif_top_props #(.ADDR_W(ADDR_W), .N_FLT(N_FLT)) u_props (.sys_clk(sys_clk), .rst_b(rst_b),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .filter_hit(filter_hit), .route_valid(route_valid), .route_fifo(route_fifo),
   .module_on(module_on));

// *** dv/cif_fifo_model.sv ***
// fill-level model of the controller's fifos as the flag logic sees them
module cif_fifo_model #(
   parameter int N_FIFO = 16,         // fifos modelled
   parameter int DEPTH  = 4           // small depth keeps fills short
) (
   input  wire logic         sys_clk,
   output logic [N_FIFO-1:0] full,
   output logic [N_FIFO-1:0] half,
   output logic [N_FIFO-1:0] empty,
   output logic [N_FIFO-1:0] msg_arrive
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt [N_FIFO] = '{default: 0};  // messages held per fifo
   initial begin
      msg_arrive <= '0;
   end
   // levels follow the count at once, nothing is latched here
   always_comb begin
      for (int i = 0; i < N_FIFO; i++) begin
         full[i]  = (cnt[i] == DEPTH);
         half[i]  = (cnt[i] >= DEPTH / 2);
         empty[i] = (cnt[i] == 0);
      end
   end
   // count moves after the arrival edge, so a full fifo still reads full when it is hit
   task automatic push(input int n);
      @(posedge sys_clk);
      msg_arrive[n] <= 1'b1;
      @(posedge sys_clk);
      msg_arrive[n] <= 1'b0;
      if (cnt[n] < DEPTH) cnt[n] <= cnt[n] + 1;
   endtask
endmodule : cif_fifo_model

// *** dv/cif_top_test.sv ***
// directed apb tests of the interrupt, filter and fifo flag block
module cif_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   import cif_pkg::*;
   logic              sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
   logic              irq, route_valid, module_on;
   logic [7:0]        paddr;
   cif_word_t         pwdata, prdata, rd;
   logic [8:0]        module_evt;
   logic [2:0]        filter_hit;
   logic [15:0]       dir_tx, f_full, f_half, f_empty, f_arr;
   logic [4:0]        route_fifo;
   logic [1:0]        route_mask_sel;
   int                miscompares, tests_run, cyc, b;

   cif_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .module_evt(module_evt), .filter_hit(filter_hit), .fifo_direction_tx(dir_tx), .fifo_full(f_full),
      .fifo_half(f_half), .fifo_empty(f_empty), .fifo_msg_arrive(f_arr), .irq(irq),
      .route_valid(route_valid), .route_fifo(route_fifo), .route_mask_sel(route_mask_sel),
      .module_on(module_on));
   cif_fifo_model fm (.sys_clk(sys_clk), .full(f_full), .half(f_half), .empty(f_empty), .msg_arrive(f_arr));

   // 250 mhz clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // four-state compare so an unknown never passes
   task automatic chk32(input cif_word_t got, input cif_word_t exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk32({31'h0, got}, {31'h0, exp});
   endtask
   // one apb transfer; waits for ready rather than assuming a latency
   task automatic apb(input logic w, input logic [7:0] a, input cif_word_t d);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input cif_word_t d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input cif_word_t e);
      apb(1'b0, a, 32'h0);
      chk32(rd, e);
   endtask
   // one-cycle event, then time for flag and irq to land
   task automatic evt(input logic [8:0] m);
      @(posedge sys_clk);
      module_evt <= m;
      @(posedge sys_clk);
      module_evt <= '0;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic hit(input logic [2:0] h, input logic v, input logic [4:0] f, input logic [1:0] m);
      @(posedge sys_clk);
      filter_hit <= h;
      @(posedge sys_clk);
      filter_hit <= '0;
      #1;
      chk1(route_valid, v);
      if (v) chk32({25'h0, route_mask_sel, route_fifo}, {25'h0, m, f});
   endtask
   // let a registered output catch up with the last write
   task automatic settle();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic test_done();
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // hang guard, far above the few hundred cycles the tests need
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         test_done();
      end
   end

   initial begin
      {rst_b, psel, penable, pwrite, paddr, pwdata, module_evt, filter_hit} = '0;
      dir_tx = 16'h0008;                    // fifo 3 transmits, the rest receive
      {miscompares, tests_run, cyc} = '0;
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      rdc(8'h00, 32'h0);
      rdc(8'h04, 32'h0);
      rdc(8'h4c, 32'h0000_0500);
      wr(8'h00, 32'hffff_ffff);
      rdc(8'h00, 32'hf80f_0000);
      apb(1'b0, 8'h0c, 32'h0);
      chk1(err, 1'b1);
      apb(1'b1, 8'h02, 32'h0);
      chk1(err, 1'b1);
      $display("test registers done");
      for (int i = 0; i < 9; i++) begin
         if (i == 5) continue;
         b = (i > 3) ? i + 7 : i;
         evt(9'h001 << i);
         chk1(irq, 1'b1);
         rdc(8'h00, 32'hf80f_0000 | (32'h1 << b));
         wr(8'h00, 32'hf80f_0000 | (32'h1 << b));
         rdc(8'h00, 32'hf80f_0000);
         chk1(irq, 1'b0);
      end
      wr(8'h00, 32'h0);
      evt(9'h100);
      chk1(irq, 1'b0);
      rdc(8'h00, 32'h0000_8000);
      wr(8'h00, 32'h1000_8000);
      evt(9'h020);
      chk1(irq, 1'b1);
      wr(8'h00, 32'h1000_1000);
      rdc(8'h00, 32'h1000_1000);
      wr(8'h08, 32'h0);
      wr(8'h08, 32'h0000_8000);
      settle();
      chk1(module_on, 1'b1);
      rdc(8'h00, 32'h1000_0000);
      wr(8'h00, 32'h0);
      $display("test events done");
      wr(8'h04, 32'hffb0_efc5);
      rdc(8'h04, 32'h00b0_efc5);
      hit(3'b001, 1'b1, 5'd5, 2'd2);
      hit(3'b010, 1'b1, 5'd15, 2'd3);
      hit(3'b100, 1'b0, 5'd0, 2'd0);
      hit(3'b011, 1'b1, 5'd5, 2'd2);
      wr(8'h04, 32'h00b0_e3c1);
      rdc(8'h04, 32'h00b0_efc5);
      wr(8'h04, 32'h0);
      rdc(8'h04, 32'h0030_6f45);
      hit(3'b001, 1'b0, 5'd0, 2'd0);
      wr(8'h04, 32'h0000_0001);
      rdc(8'h04, 32'h0000_0001);
      $display("test filters done");
      wr(8'h4c, 32'hffff_ffff);
      rdc(8'h4c, 32'h070f_0500);
      chk1(irq, 1'b1);
      repeat (4) fm.push(3);
      rdc(8'h4c, 32'h070f_0200);
      wr(8'h4c, 32'h0);
      settle();
      chk1(irq, 1'b0);
      fm.push(1);
      rdc(8'h44, 32'h0000_0001);
      repeat (3) fm.push(1);
      rdc(8'h44, 32'h0000_0007);
      fm.push(1);
      rdc(8'h44, 32'h0000_000f);
      wr(8'h44, 32'h000f_0008);
      rdc(8'h44, 32'h000f_000f);
      chk1(irq, 1'b1);
      wr(8'h44, 32'h0);
      rdc(8'h44, 32'h0000_0007);
      chk1(irq, 1'b0);
      $display("test fifos done");
      test_done();
   end
endmodule : cif_top_test
